// ---- hdl/sleepy_node_poll_timeout_ctrl.sv ----
// Sleep, poll and parent-loss control of a cyclic sleep end node
// Assumes link events are one-cycle pulses synchronous to mclk
`timescale 1ns/1ps
`include "sleepy_cfg.svh"
module sleepy_node_poll_timeout_ctrl import sleepy_pkg::*; #(
  parameter int TICK_CYCLES = `MS_TICK_CYCLES
) (
  input  wire logic        mclk,                // 40 MHz clock
  input  wire logic        rst_n,               // Async reset, active low
  input  wire logic        ce,                  // Clock enable, freezes state
  input  wire regReq_t     regReq,              // Register access
  output logic [31:0]      regRdata,            // Read data, cycle after read
  input  wire logic        commissionButtonPin, // Button, active low press
  input  wire logic        pinWake,             // Wake pin for mode 5
  input  wire linkIn_t     linkIn,              // Radio stack events
  input  wire logic [63:0] scanPanId,           // Network id found by scan
  output linkOut_t         linkOut,             // Radio stack requests
  output logic             awakeInd             // On/sleep indicator
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Register address match
  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : isAddr

  // Choose association instead of rejoin
  function automatic logic pickAssoc(input logic [7:0] nj, input logic [1:0] fails);
    return (nj == `NJ_ASSOC_ONLY) || (fails >= `REJOIN_TRIES);
  endfunction : pickAssoc

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        msTick;
  logic        pbEn_r;
  logic [2:0]  sleepMode_r;
  logic [11:0] sleepPeriod_r;
  logic [15:0] sleepCount_r;
  logic [15:0] untilSleep_r;
  logic [7:0]  joinWindow_r;
  logic [15:0] regPoll_r;
  logic [63:0] ownPanId_r;
  nodeState_t  state_r, stateNxt;
  logic [15:0] tmr_r, tmrNxt;
  logic [15:0] pollTmr_r, pollIvl_r, pollIvlNxt;
  logic [15:0] stCnt_r, btnCnt_r;
  logic [15:0] wakeCnt_r, wakeCntNxt;
  logic [1:0]  missCnt_r, missNxt, rejoinFail_r, failNxt;
  logic        ackWait_r, ackWaitNxt;
  logic        indOn_r, indNxt;
  logic        btnPrev_r;
  linkOut_t    reqNxt;
  logic        goSearch, goSleep;

  // Tick source
  ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .msTick (msTick)
  );

  // ****************************************************************
  // Event decoding
  // ****************************************************************
  wire tick       = ce & msTick;
  wire btnFall    = btnPrev_r & ~commissionButtonPin;
  wire btnWake    = pbEn_r & btnFall;
  wire cyclic     = (sleepMode_r == `MODE_CYCLIC) || (sleepMode_r == `MODE_CYC_PIN);
  wire pinWakeNow = (sleepMode_r == `MODE_CYC_PIN) & pinWake;
  wire rxIn       = linkIn.rxData;
  wire dataIn     = linkIn.rxData | linkIn.serialData;
  wire stRun      = (stCnt_r != 16'h0000);
  wire wakeForced = btnWake | pinWakeNow | ~cyclic;
  wire stayAwake  = stRun | (btnCnt_r != 16'h0000) | wakeForced;
  wire lost       = (missCnt_r == `MISS_LIMIT);
  wire panMatch   = (scanPanId == ownPanId_r);
  wire pollFire   = (pollTmr_r == 16'h0000) & ~ackWait_r;
  wire [15:0] tmrDec  = (tick && tmr_r != 16'h0000) ? tmr_r - 16'h0001 : tmr_r;
  wire [15:0] sleepMs = 16'({4'h0, sleepPeriod_r} * `SP_UNIT_MS);
  wire [15:0] wakeInc = 16'(wakeCnt_r + 16'h0001);
  wire [16:0] ivlDbl  = {pollIvl_r, 1'b0};

  // Register strobes
  wire wrCtrl   = regReq.wr & isAddr(regReq.addr, `OFS_CTRL);
  wire sleepCmd = regReq.wr & isAddr(regReq.addr, `OFS_CMD) & regReq.wdata[`CMD_SLEEP_BIT];

  // Adaptive interval: fast after data, doubled per poll up to regular rate
  always_comb begin
    if (rxIn)
      pollIvlNxt = `FAST_POLL_MS;
    else if (reqNxt.pollReq)
      pollIvlNxt = (ivlDbl >= {1'b0, regPoll_r}) ? regPoll_r : ivlDbl[15:0];
    else
      pollIvlNxt = pollIvl_r;
  end

  // ****************************************************************
  // Node state machine
  // ****************************************************************
  always_comb begin
    stateNxt   = state_r;
    tmrNxt     = tmrDec;
    reqNxt     = '0;
    missNxt    = missCnt_r;
    ackWaitNxt = ackWait_r;
    failNxt    = rejoinFail_r;
    wakeCntNxt = wakeCnt_r;
    indNxt     = indOn_r | rxIn | btnWake | pinWakeNow;
    goSearch   = 1'b0;
    goSleep    = 1'b0;
    // Acknowledge window of the last poll
    if (linkIn.pollAck) begin
      missNxt    = 2'h0;
      ackWaitNxt = 1'b0;
    end else if (ackWait_r && tmr_r == 16'h0000) begin
      missNxt    = missCnt_r + 2'h1;
      ackWaitNxt = 1'b0;
    end
    case (state_r)
      ST_ORPHAN: begin
        reqNxt.orphanScanReq = 1'b1;
        tmrNxt               = `ORPHAN_WAIT_MS;
        stateNxt             = ST_ORPHWAIT;
      end
      ST_ORPHWAIT: begin
        if (linkIn.orphanResp)
          goSleep = 1'b1;
        else if (tmr_r == 16'h0000)
          goSearch = 1'b1;
      end
      ST_SLEEP: begin
        if (tmr_r == 16'h0000 || wakeForced) begin
          stateNxt       = ST_POLL1;
          reqNxt.pollReq = 1'b1;
          ackWaitNxt     = 1'b1;
          tmrNxt         = `ACK_WAIT_MS;
          if (wakeInc >= sleepCount_r) begin
            wakeCntNxt = 16'h0000;
            indNxt     = 1'b1;
          end else begin
            wakeCntNxt = wakeInc;
          end
        end
      end
      ST_POLL1: begin
        if (lost)
          goSearch = 1'b1;
        else if (!ackWait_r && (stayAwake || dataIn))
          stateNxt = ST_AWAKE;
        else if (!ackWait_r)
          goSleep = 1'b1;
      end
      ST_AWAKE: begin
        if (lost)
          goSearch = 1'b1;
        else if (sleepCmd || (!stayAwake && !dataIn && !ackWait_r))
          goSleep = 1'b1;
        else if (pollFire) begin
          reqNxt.pollReq = 1'b1;
          ackWaitNxt     = 1'b1;
          tmrNxt         = `ACK_WAIT_MS;
        end
      end
      ST_SCAN: begin
        if (linkIn.scanDone && panMatch) begin
          reqNxt.rejoinReq = 1'b1;
          stateNxt         = ST_REJOIN;
          tmrNxt           = `JOIN_WAIT_MS;
        end else if (linkIn.scanDone || tmr_r == 16'h0000) begin
          failNxt  = lost ? rejoinFail_r : rejoinFail_r + 2'h1;
          goSearch = 1'b1;
        end
      end
      ST_REJOIN: begin
        if (linkIn.rejoinResp) begin
          failNxt = 2'h0;
          goSleep = 1'b1;
        end else if (tmr_r == 16'h0000) begin
          failNxt  = (rejoinFail_r == `REJOIN_TRIES) ? rejoinFail_r : rejoinFail_r + 2'h1;
          goSearch = 1'b1;
        end
      end
      ST_ASSOC: begin
        if (linkIn.assocDone) begin
          failNxt = 2'h0;
          goSleep = 1'b1;
        end else if (tmr_r == 16'h0000) begin
          reqNxt.assocReq = 1'b1;
          tmrNxt          = `JOIN_WAIT_MS;
        end
      end
      default: stateNxt = ST_ORPHAN;
    endcase
    // New parent search, rejoin first unless forced to associate
    if (goSearch) begin
      missNxt    = 2'h0;
      ackWaitNxt = 1'b0;
      tmrNxt     = `JOIN_WAIT_MS;
      if (pickAssoc(joinWindow_r, failNxt)) begin
        stateNxt        = ST_ASSOC;
        reqNxt.assocReq = 1'b1;
      end else begin
        stateNxt          = ST_SCAN;
        reqNxt.panScanReq = 1'b1;
      end
    end
    // Sleep for one sleep period in cyclic modes, else go awake
    if (goSleep) begin
      stateNxt   = cyclic ? ST_SLEEP : ST_AWAKE;
      tmrNxt     = sleepMs;
      indNxt     = 1'b0;
      ackWaitNxt = 1'b0;
    end
  end

  // State and sequencing registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_ORPHAN;
      tmr_r        <= 16'h0000;
      missCnt_r    <= 2'h0;
      ackWait_r    <= 1'b0;
      rejoinFail_r <= 2'h0;
      wakeCnt_r    <= 16'h0000;
      indOn_r      <= 1'b0;
      linkOut      <= '0;
      awakeInd     <= 1'b0;
    end else if (ce) begin
      state_r      <= stateNxt;
      tmr_r        <= tmrNxt;
      missCnt_r    <= missNxt;
      ackWait_r    <= ackWaitNxt;
      rejoinFail_r <= failNxt;
      wakeCnt_r    <= wakeCntNxt;
      indOn_r      <= indNxt;
      linkOut      <= reqNxt;
      awakeInd     <= indNxt && (stateNxt != ST_SLEEP);
    end
  end

  // Poll interval timer and adaptive rate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pollTmr_r <= 16'h0000;
      pollIvl_r <= `REG_POLL_MS;
    end else if (ce) begin
      pollIvl_r <= pollIvlNxt;
      if (reqNxt.pollReq)
        pollTmr_r <= pollIvlNxt;
      else if (rxIn)
        pollTmr_r <= `FAST_POLL_MS;
      else if (tick && pollTmr_r != 16'h0000)
        pollTmr_r <= pollTmr_r - 16'h0001;
    end
  end

  // Time-until-sleep and button wake windows
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stCnt_r   <= 16'h0000;
      btnCnt_r  <= 16'h0000;
      btnPrev_r <= 1'b1;
    end else if (ce) begin
      btnPrev_r <= commissionButtonPin;
      if (cyclic && dataIn && state_r != ST_SLEEP)
        stCnt_r <= untilSleep_r;
      else if (sleepCmd || (tick && stRun))
        stCnt_r <= sleepCmd ? 16'h0000 : stCnt_r - 16'h0001;
      if (btnWake)
        btnCnt_r <= `BTN_WAKE_MS;
      else if (tick && btnCnt_r != 16'h0000)
        btnCnt_r <= btnCnt_r - 16'h0001;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pbEn_r        <= 1'b0;
      sleepMode_r   <= 3'h0;
      sleepPeriod_r <= `RST_SP;
      sleepCount_r  <= `RST_SN;
      untilSleep_r  <= `RST_ST;
      joinWindow_r  <= `RST_NJ;
      regPoll_r     <= `REG_POLL_MS;
      ownPanId_r    <= `RST_PAN;
    end else if (ce && regReq.wr) begin
      if (wrCtrl) begin
        pbEn_r      <= regReq.wdata[`CTRL_PB_BIT];
        sleepMode_r <= regReq.wdata[`CTRL_MODE_LSB +: 3];
      end
      if (isAddr(regReq.addr, `OFS_SP))    sleepPeriod_r      <= regReq.wdata[11:0];
      if (isAddr(regReq.addr, `OFS_SN))    sleepCount_r       <= regReq.wdata[15:0];
      if (isAddr(regReq.addr, `OFS_ST))    untilSleep_r       <= regReq.wdata[15:0];
      if (isAddr(regReq.addr, `OFS_NJ))    joinWindow_r       <= regReq.wdata[7:0];
      if (isAddr(regReq.addr, `OFS_PO))    regPoll_r          <= regReq.wdata[15:0];
      if (isAddr(regReq.addr, `OFS_PANLO)) ownPanId_r[31:0]   <= regReq.wdata;
      if (isAddr(regReq.addr, `OFS_PANHI)) ownPanId_r[63:32]  <= regReq.wdata;
    end
  end

  // Read selection, unmapped addresses read zero
  wire [31:0] statusWord = {22'h0, awakeInd, stRun, rejoinFail_r, missCnt_r, ackWait_r, state_r};
  wire [31:0] rdSel =
      isAddr(regReq.addr, `OFS_CTRL)   ? {28'h0, sleepMode_r, pbEn_r} :
      isAddr(regReq.addr, `OFS_SP)     ? {20'h0, sleepPeriod_r} :
      isAddr(regReq.addr, `OFS_SN)     ? {16'h0, sleepCount_r} :
      isAddr(regReq.addr, `OFS_ST)     ? {16'h0, untilSleep_r} :
      isAddr(regReq.addr, `OFS_NJ)     ? {24'h0, joinWindow_r} :
      isAddr(regReq.addr, `OFS_PO)     ? {16'h0, regPoll_r} :
      isAddr(regReq.addr, `OFS_PANLO)  ? ownPanId_r[31:0] :
      isAddr(regReq.addr, `OFS_PANHI)  ? ownPanId_r[63:32] :
      isAddr(regReq.addr, `OFS_STATUS) ? statusWord : 32'h0000_0000;

  // Read data register, valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      regRdata <= 32'h0000_0000;
    else if (ce)
      regRdata <= regReq.rd ? rdSel : 32'h0000_0000;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_btn_wake_load: assert property (ce && btnWake |=> btnCnt_r == `BTN_WAKE_MS)
    else $error("button wake window not loaded");
  a_single_poll_sleep: assert property (ce && state_r == ST_POLL1 && !ackWait_r && !lost
      && !stayAwake && !dataIn && cyclic |=> state_r == ST_SLEEP && tmr_r == sleepMs)
    else $error("single wake poll did not return to sleep");
  a_awake_poll_fire: assert property (ce && state_r == ST_AWAKE && pollFire && !lost && !sleepCmd
      && (stayAwake || dataIn) |=> linkOut.pollReq ##1 !linkOut.pollReq)
    else $error("awake poll not issued");
  a_parent_lost: assert property (ce && lost && (state_r == ST_POLL1 || state_r == ST_AWAKE)
      |=> (state_r == ST_SCAN || state_r == ST_ASSOC) && missCnt_r == 2'h0)
    else $error("lost parent did not start a search");
  a_orphan_timeout: assert property (ce && state_r == ST_ORPHWAIT && tmr_r == 16'h0000
      && !linkIn.orphanResp |=> state_r == ST_SCAN || state_r == ST_ASSOC)
    else $error("orphan scan timeout did not start a search");
  a_rejoin_match: assert property (ce && state_r == ST_SCAN && linkIn.scanDone && panMatch
      |=> linkOut.rejoinReq && state_r == ST_REJOIN)
    else $error("matching network did not get a rejoin request");
  a_assoc_only: assert property (ce && goSearch && joinWindow_r == `NJ_ASSOC_ONLY
      |=> state_r == ST_ASSOC && linkOut.assocReq)
    else $error("join window 0xFF did not use association");
  a_fast_poll: assert property (ce && rxIn |=> pollIvl_r == `FAST_POLL_MS)
    else $error("radio data did not select fast polling");
  a_ind_on_data: assert property (ce && state_r != ST_SLEEP && rxIn && !goSleep |=> awakeInd)
    else $error("awake indicator not set on radio data");
  a_sleep_cmd: assert property (ce && state_r == ST_AWAKE && sleepCmd && !lost && cyclic
      |=> state_r == ST_SLEEP ##1 !awakeInd)
    else $error("sleep command ignored");

  c_orphan_ok: cover property (state_r == ST_ORPHWAIT && linkIn.orphanResp);
  c_rejoin_ok: cover property (state_r == ST_REJOIN && linkIn.rejoinResp);
  c_poll_back: cover property (state_r == ST_POLL1 ##[1:40] state_r == ST_SLEEP);
  c_lost: cover property (lost && state_r == ST_AWAKE);

endmodule : sleepy_node_poll_timeout_ctrl

// ---- shared/sleepy_cfg.svh ----
// Constants for the sleepy end node poll and timeout controller
// Assumes a 40 MHz mclk and a 1 ms tick derived from it
`ifndef SLEEPY_CFG_SVH
`define SLEEPY_CFG_SVH

// ****************************************************************
// Clock and tick
// ****************************************************************
`define MCLK_PERIOD_NS 25
`define MS_TICK_NS     1000000
`define MS_TICK_CYCLES (`MS_TICK_NS / `MCLK_PERIOD_NS)

// ****************************************************************
// Timing in milliseconds, BTN_WAKE_S in seconds
// ****************************************************************
`define BTN_WAKE_S     30
`define BTN_WAKE_MS    16'(`BTN_WAKE_S * 1000)
`define REG_POLL_MS    16'h0064
`define FAST_POLL_MS   16'h000A
`define ACK_WAIT_MS    16'h0014
`define ORPHAN_WAIT_MS 16'h03E8
`define JOIN_WAIT_MS   16'h07D0
`define SP_UNIT_MS     16'h000A

// ****************************************************************
// Limits and codes
// ****************************************************************
`define MISS_LIMIT     2'h3
`define REJOIN_TRIES   2'h3
`define NJ_ASSOC_ONLY  8'hFF
`define MODE_CYCLIC    3'h4
`define MODE_CYC_PIN   3'h5

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_CTRL   8'h00
`define OFS_SP     8'h04
`define OFS_SN     8'h08
`define OFS_ST     8'h0C
`define OFS_NJ     8'h10
`define OFS_PO     8'h14
`define OFS_PANLO  8'h18
`define OFS_PANHI  8'h1C
`define OFS_CMD    8'h20
`define OFS_STATUS 8'h24

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_PB_BIT    0
`define CTRL_MODE_LSB  1
`define CMD_SLEEP_BIT  0
`define RST_SP         12'h020
`define RST_SN         16'h0001
`define RST_ST         16'h1388
`define RST_NJ         8'hFF
`define RST_PAN        64'h0000_0000_0000_0000

`endif

// ---- shared/sleepy_pkg.sv ----
// Types shared by the sleepy end node controller files
// Assumes nothing beyond the constants header
package sleepy_pkg;

  // Node states, Gray coded along reset, sleep, poll, awake, search
  typedef enum logic [2:0] {
    ST_ORPHAN   = 3'h0,
    ST_ORPHWAIT = 3'h1,
    ST_SLEEP    = 3'h3,
    ST_POLL1    = 3'h2,
    ST_AWAKE    = 3'h6,
    ST_SCAN     = 3'h7,
    ST_REJOIN   = 3'h5,
    ST_ASSOC    = 3'h4
  } nodeState_t;

  // Events reported by the radio stack, one-cycle pulses
  typedef struct packed {
    logic pollAck;
    logic rxData;
    logic serialData;
    logic orphanResp;
    logic scanDone;
    logic rejoinResp;
    logic assocDone;
  } linkIn_t;

  // Requests to the radio stack, one-cycle pulses
  typedef struct packed {
    logic pollReq;
    logic orphanScanReq;
    logic panScanReq;
    logic rejoinReq;
    logic assocReq;
  } linkOut_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } regReq_t;

endpackage : sleepy_pkg

// ---- hdl/ms_tick_gen.sv ----
// Millisecond tick divider for the sleepy node controller
// Assumes mclk runs at the rate the tick count is derived for
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int TICK_CYCLES = 40000
) (
  input  wire logic mclk,   // System clock
  input  wire logic rst_n,  // Async reset, active low
  input  wire logic ce,     // Clock enable
  output logic      msTick  // One-cycle pulse each ms
);

  logic [15:0] divCnt_r;
  wire         wrap = (divCnt_r == 16'(TICK_CYCLES - 1));

  // Divide mclk down to the 1 ms tick
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 16'h0000;
      msTick   <= 1'b0;
    end else if (ce) begin
      divCnt_r <= wrap ? 16'h0000 : divCnt_r + 16'h0001;
      msTick   <= wrap;
    end
  end

endmodule : ms_tick_gen

// ---- sim/parent_stack_model.sv ----
// Radio stack and parent node standing beside the sleepy node controller
// Assumes one-cycle request pulses from the node, answers as pulses too
`timescale 1ns/1ps
module parent_stack_model import sleepy_pkg::*; #(
  parameter int MS = 4                 // Bench cycles per millisecond
) (
  input  wire logic        mclk,     // Clock
  input  wire logic        rst_n,    // Reset, active low
  input  wire linkOut_t    linkOut,  // Requests from the node
  input  wire logic [3:0]  ackDly,   // Poll answer delay, 1 to 15 cycles
  input  wire logic        ackOn,    // Parent answers polls
  input  wire logic        rxOn,     // Parent holds data for the node
  input  wire logic        orphOn,   // Parent answers orphan scans
  input  wire logic [63:0] panId,    // Network id on the air
  output linkIn_t          linkIn,   // Events to the node
  output logic [63:0]      scanPanId // Id reported by a scan
);
  // Parent settings matching the node, timeouts in bench cycles
  localparam int SPV   = 32;  // Sleep period, 10 ms units
  localparam int SNV   = 1;   // Sleep count
  localparam int NHV   = 4;   // Hop setting
  localparam int SLOTS = 2;   // Child table size
  localparam int BUFT  = MS * ((SPV * 12 < 1200) ? 1200 : (SPV * 12 > 30000) ? 30000 : SPV * 12);
  localparam int CPT   = MS * ((3 * SPV * 10 * SNV < 5000) ? 5000 : 3 * SPV * 10 * SNV);
  localparam int TXT   = MS * 3 * (50 * NHV + 12 * SPV);
  logic [3:0] ackCnt_r;
  int         bufAge_r, childAge_r, tries_r, freeSlots_r;
  logic       childIn_r;
  wire        held  = rxOn && (bufAge_r < BUFT);
  wire        admit = (freeSlots_r != 0);
  // Answers one cycle after each request, poll answers after a delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linkIn      <= '0;
      ackCnt_r    <= '0;
      scanPanId   <= '0;
      bufAge_r    <= 0;
      childAge_r  <= 0;
      tries_r     <= 0;
      freeSlots_r <= SLOTS - 1;
      childIn_r   <= 1'b1;
    end else begin
      linkIn    <= '0;
      scanPanId <= ~scanPanId; // Unqualified id never holds still
      ackCnt_r  <= linkOut.pollReq ? ackDly : ackCnt_r - 4'(ackCnt_r != 4'h0);
      if (ackCnt_r == 4'h1 && ackOn && childIn_r) begin
        linkIn.pollAck <= 1'b1;
        linkIn.rxData  <= held;
      end
      // Buffered data ages until delivered, resent at most two more times
      if (!rxOn || linkIn.rxData) begin
        bufAge_r <= 0;
        tries_r  <= 0;
      end else if (bufAge_r == TXT - 1 && tries_r < 2) begin
        bufAge_r <= 0;
        tries_r  <= tries_r + 1;
      end else
        bufAge_r <= bufAge_r + 1;
      // A child silent for the poll timeout leaves the table
      if (linkOut.pollReq)
        childAge_r <= 0;
      else if (childAge_r == CPT - 1 && childIn_r) begin
        childIn_r   <= 1'b0;
        freeSlots_r <= freeSlots_r + 1;
      end else
        childAge_r <= childAge_r + 1;
      if ((linkOut.rejoinReq || linkOut.assocReq) && admit && !childIn_r) begin
        childIn_r   <= 1'b1;
        freeSlots_r <= freeSlots_r - 1;
      end
      linkIn.orphanResp <= linkOut.orphanScanReq && orphOn;
      linkIn.rejoinResp <= linkOut.rejoinReq && admit;
      linkIn.assocDone  <= linkOut.assocReq && admit;
      if (linkOut.panScanReq) begin
        linkIn.scanDone <= 1'b1;
        scanPanId       <= panId;
      end
    end
  end
endmodule : parent_stack_model

// ---- sim/sleepy_node_poll_timeout_ctrl_tb.sv ----
// Self-checking bench for the sleepy node poll and timeout controller
// Assumes parent_stack_model beside it and a 4-cycle millisecond tick
`timescale 1ns/1ps
module sleepy_node_poll_timeout_ctrl_tb import sleepy_pkg::*;;
  localparam int TK = 4;
  logic        mclk, rst_n, btn, ackOn, rxOn, awakeInd;
  logic [3:0]  ackDly;
  logic [63:0] panId, scanPanId;
  logic [31:0] regRdata, d;
  regReq_t     regReq;
  linkIn_t     linkIn;
  linkOut_t    linkOut;
  int          failures, n_compared, c, c2, k;
  logic [7:0]  ad [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
  logic [31:0] ex [11] = '{32'h0, 32'h20, 32'h1, 32'h1388, 32'hFF, 32'h64, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

  sleepy_node_poll_timeout_ctrl #(.TICK_CYCLES(TK)) sleepy_node_poll_timeout_ctrl_inst (
    .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .regReq(regReq), .regRdata(regRdata),
    .commissionButtonPin(btn), .pinWake(1'b0), .linkIn(linkIn), .scanPanId(scanPanId),
    .linkOut(linkOut), .awakeInd(awakeInd));
  parent_stack_model #(.MS(TK)) parent_stack_model_inst (
    .mclk(mclk), .rst_n(rst_n), .linkOut(linkOut), .ackDly(ackDly), .ackOn(ackOn), .rxOn(rxOn),
    .orphOn(1'b0), .panId(panId), .linkIn(linkIn), .scanPanId(scanPanId));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int ms2cyc(input int ms);
    return ms * TK;
  endfunction : ms2cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // Register write or read, entered at a rising edge; read data lands in d
  task automatic acc(input logic [7:0] a, input logic [31:0] w, input logic wr);
    regReq <= '{a, w, wr, !wr};
    @(posedge mclk);
    regReq <= '0;
    @(negedge mclk);
    d = regRdata;
    @(posedge mclk);
  endtask : acc
  // Bounded wait for request bit i of linkOut, n counts the cycles
  task automatic waitReq(input int i, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > lim) begin
        chk("request wait", 0, 1);
        report_and_stop();
      end
    end while (!linkOut[i]);
  endtask : waitReq

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    void'($urandom(32'hCCD0D4A4));
    failures = 0; n_compared = 0; rst_n = 1'b0; btn = 1'b1; ackOn = 1'b1; rxOn = 1'b0; regReq = '0;
    ackDly = 4'($urandom_range(15, 1));
    panId = {$urandom, $urandom};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    waitReq(3, 5, c);
    for (k = 0; k < 11; k++) begin
      acc(ad[k], 32'h0, 1'b0);
      chk("reset value", ex[k], d);
    end
    waitReq(0, ms2cyc(1000) + 40, c);
    waitReq(4, ms2cyc(200), c);
    waitReq(4, ms2cyc(200), c);
    chk("poll gap", 1, c >= ms2cyc(100) - 4 && c <= ms2cyc(100) + 4);
    rxOn <= 1'b1;
    waitReq(4, ms2cyc(200), c);
    repeat (16) @(posedge mclk);
    rxOn <= 1'b0;
    waitReq(4, ms2cyc(200), c);
    waitReq(4, ms2cyc(200), c2);
    chk("fast poll", 1, c < ms2cyc(100) && c2 > c);
    acc(8'h10, 32'h10, 1'b1);
    acc(8'h18, panId[31:0], 1'b1);
    acc(8'h1C, panId[63:32], 1'b1);
    acc(8'h00, 32'h8, 1'b1);
    waitReq(4, ms2cyc(400), c);
    repeat (16) @(posedge mclk);
    ackOn <= 1'b0;
    k = 0;
    c = 0;
    while (!linkOut.panScanReq && c < ms2cyc(3000)) begin
      @(posedge mclk);
      c++;
      if (linkOut.pollReq) k++;
    end
    chk("polls before search", 3, k);
    chk("rejoin scan", 1, linkOut.panScanReq);
    ackOn <= 1'b1;
    waitReq(1, 10, c);
    waitReq(4, ms2cyc(400), c);
    waitReq(4, ms2cyc(400), c);
    chk("single poll then sleep", 1, c >= ms2cyc(320) - 4);
    acc(8'h08, 32'h3, 1'b1);
    k = 0;
    repeat (6) begin
      waitReq(4, ms2cyc(400), c);
      @(posedge mclk);
      k += awakeInd;
    end
    chk("indicated wakes", 2, k);
    acc(8'h00, 32'h9, 1'b1);
    btn <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("button wake", 1, awakeInd);
    repeat (ms2cyc(1000)) @(posedge mclk);
    chk("button window", 1, awakeInd);
    btn <= 1'b1;
    acc(8'h20, 32'h1, 1'b1);
    repeat (4) @(posedge mclk);
    chk("sleep command", 0, awakeInd);
    report_and_stop();
  end
endmodule : sleepy_node_poll_timeout_ctrl_tb
